// file: src/bwmd_pkg.sv
// constants and carrier types for the blit write-mask and direction block
`default_nettype none
package bwmd_pkg;
   // ----------------------------------------------------------------
   // register byte addresses
   // ----------------------------------------------------------------
   localparam logic [4:0]  BWMD_ADDR_CTRL   = 5'h00;
   localparam logic [4:0]  BWMD_ADDR_BG     = 5'h04;
   localparam logic [4:0]  BWMD_ADDR_SIZE   = 5'h08;
   localparam logic [4:0]  BWMD_ADDR_CMD    = 5'h0c;
   localparam logic [4:0]  BWMD_ADDR_STATUS = 5'h10;
   localparam logic [4:0]  BWMD_ADDR_COUNT  = 5'h14;
   // ----------------------------------------------------------------
   // control word fields
   // ----------------------------------------------------------------
   localparam int          BWMD_ROP_LSB     = 0;
   localparam int          BWMD_XREV_BIT    = 8;
   localparam int          BWMD_YREV_BIT    = 9;
   localparam int          BWMD_SRC_MONO    = 12;
   localparam int          BWMD_SRC_MASK    = 13;
   localparam int          BWMD_CMP_EN      = 14;
   localparam int          BWMD_CMP_ROP     = 15;
   localparam int          BWMD_CMP_EQ      = 16;
   localparam int          BWMD_PAT_MASK    = 17;
   localparam int          BWMD_PAT_MONO    = 18;
   localparam int          BWMD_SIZE_H_LSB  = 16;
   localparam int          BWMD_CMD_START   = 0;
   localparam logic [31:0] BWMD_CTRL_RESET  = 32'h0000_00cc;
   localparam logic [23:0] BWMD_BG_RESET    = 24'h00_0000;
   localparam logic [7:0]  BWMD_ROP_SRC     = 8'hcc;
   localparam logic [7:0]  BWMD_ROP_PAT     = 8'hf0;
   localparam logic [7:0]  BWMD_ROP_DST     = 8'haa;
   localparam int          BWMD_PIX_W       = 24;
   localparam int          BWMD_BYTES       = 3;
   localparam int          BWMD_CRD_W       = 12;
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      BWMD_IDLE  = 3'b001,
      BWMD_RUN   = 3'b010,
      BWMD_FLUSH = 3'b100
   } bwmd_fsm_type;

   typedef struct packed {
      logic [BWMD_PIX_W-1:0] src;
      logic [BWMD_PIX_W-1:0] pat;
      logic [BWMD_PIX_W-1:0] dst;
      logic                  src_mono;
      logic                  pat_mono;
   } bwmd_pix_in_type;

   typedef struct packed {
      logic [BWMD_PIX_W-1:0] pixel;
      logic [BWMD_BYTES-1:0] byte_en;
      logic [BWMD_CRD_W-1:0] x;
      logic [BWMD_CRD_W-1:0] y;
      logic                  last;
   } bwmd_pix_out_type;
endpackage
`default_nettype wire

// file: src/bwmd_engine.sv
// blit write-mask and traversal-order engine with an avalon-mm register slave
//
// How it works
// - only monochrome source or pattern can mask
// - bits 13 and 17 pick source/pattern mask
// - mask bit zero blocks every pixel byte
// - bit 14 enables colour compare masking
// - bit 15 compares destination or rop result
// - bit 16 writes on equal or unequal
// - default start top-left, line by line
// - bits 8 and 9 choose starting corner
// - bottom-right start walks left then up
// - four distinct compare masking behaviours exist
// - compare uses the expansion background colour
// - rop code per bit; cc/f0/aa pass-through
`default_nettype none
module bwmd_engine
   import bwmd_pkg::*;
(
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   input  wire logic [4:0]       avs_address_in,
   input  wire logic             avs_read_in,
   input  wire logic             avs_write_in,
   input  wire logic [31:0]      avs_writedata_in,
   output var  logic [31:0]      avs_readdata_out,
   output var  logic             avs_waitrequest_out,
   input  wire logic             pix_valid_in,
   input  wire bwmd_pix_in_type  pix_in,
   output var  logic             pix_ready_out,
   output var  logic             out_valid_out,
   output var  bwmd_pix_out_type out_out,
   input  wire logic             out_ready_in,
   output var  logic             busy_out
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      bwmd_fsm_type          fsm;
      logic [31:0]           ctrl;
      logic [BWMD_PIX_W-1:0] bg;
      logic [BWMD_CRD_W-1:0] width;
      logic [BWMD_CRD_W-1:0] height;
      logic [BWMD_CRD_W-1:0] x;
      logic [BWMD_CRD_W-1:0] y;
      logic [23:0]           pix_cnt;
      logic                  done;
      logic                  rd_ack;
      logic [31:0]           rdata;
      logic                  ov;
      bwmd_pix_out_type      o;
   } bwmd_state_type;

   bwmd_state_type state_q;
   bwmd_state_type state_d;

   // ----------------------------------------------------------------
   // raster operation, one truth-table lookup per bit
   // ----------------------------------------------------------------
   function automatic logic rop_bit(input logic [7:0] code, input logic p, input logic s, input logic d);
      rop_bit = code[{p, s, d}];
   endfunction

   function automatic logic [BWMD_CRD_W-1:0] first_crd(input logic rev, input logic [BWMD_CRD_W-1:0] size);
      first_crd = rev ? size - 12'h001 : 12'h000;
   endfunction

   logic [BWMD_PIX_W-1:0] rop_res;
   genvar gi;
   generate
      for (gi = 0; gi < BWMD_PIX_W; gi++)
      begin : g_rop
         assign rop_res[gi] = rop_bit(state_q.ctrl[BWMD_ROP_LSB +: 8], pix_in.pat[gi], pix_in.src[gi],
                                      pix_in.dst[gi]);
      end
   endgenerate

   // ----------------------------------------------------------------
   // mask decisions
   // ----------------------------------------------------------------
   logic src_mask_on;
   logic pat_mask_on;
   logic mono_ok;
   logic cmp_equal;
   logic cmp_ok;
   logic write_ok;
   logic accept;
   logic [BWMD_CRD_W-1:0] x_end;
   logic [BWMD_CRD_W-1:0] y_end;
   logic line_end;
   logic rect_end;

   always_comb
   begin
      // colour data is never a mask: the mono flags gate the mask enables
      src_mask_on = state_q.ctrl[BWMD_SRC_MASK] & state_q.ctrl[BWMD_SRC_MONO];
      pat_mask_on = state_q.ctrl[BWMD_PAT_MASK] & state_q.ctrl[BWMD_PAT_MONO];
      mono_ok = (~src_mask_on | pix_in.src_mono) & (~pat_mask_on | pix_in.pat_mono);
      cmp_equal = (state_q.ctrl[BWMD_CMP_ROP] ? rop_res : pix_in.dst) == state_q.bg;
      cmp_ok = ~state_q.ctrl[BWMD_CMP_EN] | (state_q.ctrl[BWMD_CMP_EQ] ? cmp_equal : ~cmp_equal);
      write_ok = mono_ok & cmp_ok;
      x_end = first_crd(~state_q.ctrl[BWMD_XREV_BIT], state_q.width);
      y_end = first_crd(~state_q.ctrl[BWMD_YREV_BIT], state_q.height);
      line_end = state_q.x == x_end;
      rect_end = line_end & (state_q.y == y_end);
   end

   assign pix_ready_out = (state_q.fsm == BWMD_RUN) & (~state_q.ov | out_ready_in);
   assign accept = pix_valid_in & pix_ready_out;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      state_d = state_q;
      state_d.rd_ack = avs_read_in & ~state_q.rd_ack;
      if (avs_read_in & ~state_q.rd_ack)
      begin
         unique case (avs_address_in)
            BWMD_ADDR_CTRL:   state_d.rdata = state_q.ctrl;
            BWMD_ADDR_BG:     state_d.rdata = {8'h00, state_q.bg};
            BWMD_ADDR_SIZE:   state_d.rdata = {4'h0, state_q.height, 4'h0, state_q.width};
            BWMD_ADDR_STATUS: state_d.rdata = {state_q.y, state_q.x, 6'h00,
                                               state_q.done, state_q.fsm != BWMD_IDLE};
            BWMD_ADDR_COUNT:  state_d.rdata = {8'h00, state_q.pix_cnt};
            default:          state_d.rdata = 32'h0000_0000;
         endcase
      end
      if (out_ready_in)
      begin
         state_d.ov = 1'b0;
      end
      unique case (state_q.fsm)
         BWMD_IDLE:
         begin
            if (avs_write_in)
            begin
               unique case (avs_address_in)
                  BWMD_ADDR_CTRL: state_d.ctrl = avs_writedata_in;
                  BWMD_ADDR_BG:   state_d.bg = avs_writedata_in[BWMD_PIX_W-1:0];
                  BWMD_ADDR_SIZE:
                  begin
                     state_d.width = avs_writedata_in[BWMD_CRD_W-1:0];
                     state_d.height = avs_writedata_in[BWMD_SIZE_H_LSB +: BWMD_CRD_W];
                  end
                  BWMD_ADDR_CMD:
                  begin
                     if (avs_writedata_in[BWMD_CMD_START])
                     begin
                        state_d.done = 1'b0;
                        state_d.pix_cnt = 24'h00_0000;
                        state_d.x = first_crd(state_q.ctrl[BWMD_XREV_BIT], state_q.width);
                        state_d.y = first_crd(state_q.ctrl[BWMD_YREV_BIT], state_q.height);
                        // an empty rectangle finishes at once
                        if ((state_q.width == 12'h000) || (state_q.height == 12'h000))
                        begin
                           state_d.done = 1'b1;
                        end
                        else
                        begin
                           state_d.fsm = BWMD_RUN;
                        end
                     end
                  end
                  default:
                  begin
                  end
               endcase
            end
         end
         BWMD_RUN:
         begin
            if (accept)
            begin
               // masked pixels are emitted too, with no byte enables, so addresses stay in step
               state_d.ov = 1'b1;
               state_d.o.pixel = rop_res;
               state_d.o.byte_en = {BWMD_BYTES{write_ok}};
               state_d.o.x = state_q.x;
               state_d.o.y = state_q.y;
               state_d.o.last = rect_end;
               state_d.pix_cnt = state_q.pix_cnt + 24'h00_0001;
               if (rect_end)
               begin
                  state_d.fsm = BWMD_FLUSH;
               end
               else if (line_end)
               begin
                  // the whole line is done before the next one is touched
                  state_d.x = first_crd(state_q.ctrl[BWMD_XREV_BIT], state_q.width);
                  state_d.y = state_q.ctrl[BWMD_YREV_BIT] ? state_q.y - 12'h001 : state_q.y + 12'h001;
               end
               else
               begin
                  state_d.x = state_q.ctrl[BWMD_XREV_BIT] ? state_q.x - 12'h001 : state_q.x + 12'h001;
               end
            end
         end
         BWMD_FLUSH:
         begin
            if (~state_q.ov | out_ready_in)
            begin
               state_d.fsm = BWMD_IDLE;
               state_d.done = 1'b1;
            end
         end
         default:
         begin
            state_d.fsm = BWMD_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         state_q <= '0;
         state_q.fsm <= BWMD_IDLE;
         state_q.ctrl <= BWMD_CTRL_RESET;
         state_q.bg <= BWMD_BG_RESET;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // reads cost one wait cycle so read data can come from a flip-flop
   assign avs_waitrequest_out = avs_read_in & ~state_q.rd_ack;
   assign avs_readdata_out = state_q.rdata;
   assign out_valid_out = state_q.ov;
   assign out_out = state_q.o;
   assign busy_out = state_q.fsm != BWMD_IDLE;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence accept_s;
      accept;
   endsequence

   sequence start_s;
      avs_write_in && (avs_address_in == BWMD_ADDR_CMD) && avs_writedata_in[BWMD_CMD_START]
         && (state_q.fsm == BWMD_IDLE) && (state_q.width != 12'h000) && (state_q.height != 12'h000);
   endsequence

   rop_source_a: assert property (@(posedge clk_in) disable iff (rst_in)
      accept_s and (state_q.ctrl[7:0] == BWMD_ROP_SRC) |=> (out_out.pixel == $past(pix_in.src)))
      else $error("rop code cc did not pass the source");

   mono_block_a: assert property (@(posedge clk_in) disable iff (rst_in)
      accept_s and src_mask_on && !pix_in.src_mono |=> (out_out.byte_en == 3'h0))
      else $error("zero source mask bit did not block the pixel");

   colour_no_mask_a: assert property (@(posedge clk_in) disable iff (rst_in)
      accept_s and !state_q.ctrl[BWMD_SRC_MONO] && !state_q.ctrl[BWMD_PAT_MONO] && !state_q.ctrl[BWMD_CMP_EN]
      |=> (out_out.byte_en == 3'h7))
      else $error("colour data masked a pixel");

   cmp_dst_eq_a: assert property (@(posedge clk_in) disable iff (rst_in)
      accept_s and mono_ok && state_q.ctrl[BWMD_CMP_EN] && !state_q.ctrl[BWMD_CMP_ROP]
      && state_q.ctrl[BWMD_CMP_EQ] |=> (out_out.byte_en == {3{$past(pix_in.dst) == $past(state_q.bg)}}))
      else $error("destination equal compare wrote wrongly");

   cmp_rop_ne_a: assert property (@(posedge clk_in) disable iff (rst_in)
      accept_s and mono_ok && state_q.ctrl[BWMD_CMP_EN] && state_q.ctrl[BWMD_CMP_ROP]
      && !state_q.ctrl[BWMD_CMP_EQ] |=> (out_out.byte_en == {3{$past(rop_res) != $past(state_q.bg)}}))
      else $error("rop unequal compare wrote wrongly");

   all_masks_a: assert property (@(posedge clk_in) disable iff (rst_in)
      accept_s and !cmp_ok |=> out_valid_out && (out_out.byte_en == 3'h0))
      else $error("compare mask ignored while mono mask passed");

   top_left_a: assert property (@(posedge clk_in) disable iff (rst_in)
      start_s and !state_q.ctrl[BWMD_XREV_BIT] && !state_q.ctrl[BWMD_YREV_BIT]
      |=> (state_q.x == 12'h000) && (state_q.y == 12'h000) && busy_out)
      else $error("default start is not top-left");

   bottom_right_a: assert property (@(posedge clk_in) disable iff (rst_in)
      start_s and state_q.ctrl[BWMD_XREV_BIT] && state_q.ctrl[BWMD_YREV_BIT]
      |=> (state_q.x == $past(state_q.width) - 12'h001) && (state_q.y == $past(state_q.height) - 12'h001))
      else $error("bottom-right start misplaced");

   masked_count_a: assert property (@(posedge clk_in) disable iff (rst_in)
      accept_s and !write_ok |=> (state_q.pix_cnt == $past(state_q.pix_cnt) + 24'h00_0001) ##0 out_valid_out)
      else $error("masked pixel not counted");

   pat_mask_block_a: assert property (@(posedge clk_in) disable iff (rst_in)
      accept_s and pat_mask_on && !pix_in.pat_mono |=> (out_out.byte_en == 3'h0))
      else $error("zero pattern mask bit did not block the pixel");

   colour_pat_a: assert property (@(posedge clk_in) disable iff (rst_in)
      accept_s and state_q.ctrl[BWMD_PAT_MASK] && !state_q.ctrl[BWMD_PAT_MONO] && !src_mask_on
      && !state_q.ctrl[BWMD_CMP_EN] |=> (out_out.byte_en == 3'h7))
      else $error("colour pattern masked a pixel");

   cmp_off_a: assert property (@(posedge clk_in) disable iff (rst_in)
      accept_s and mono_ok && !state_q.ctrl[BWMD_CMP_EN] |=> (out_out.byte_en == 3'h7))
      else $error("compare mask applied while disabled");

   cmp_dst_ne_a: assert property (@(posedge clk_in) disable iff (rst_in)
      accept_s and mono_ok && state_q.ctrl[BWMD_CMP_EN] && !state_q.ctrl[BWMD_CMP_ROP]
      && !state_q.ctrl[BWMD_CMP_EQ] |=> (out_out.byte_en == {3{$past(pix_in.dst) != $past(state_q.bg)}}))
      else $error("destination unequal compare wrote wrongly");

   cmp_rop_eq_a: assert property (@(posedge clk_in) disable iff (rst_in)
      accept_s and mono_ok && state_q.ctrl[BWMD_CMP_EN] && state_q.ctrl[BWMD_CMP_ROP]
      && state_q.ctrl[BWMD_CMP_EQ] |=> (out_out.byte_en == {3{$past(rop_res) == $past(state_q.bg)}}))
      else $error("rop equal compare wrote wrongly");

   rop_pattern_a: assert property (@(posedge clk_in) disable iff (rst_in)
      accept_s and (state_q.ctrl[7:0] == BWMD_ROP_PAT) |=> (out_out.pixel == $past(pix_in.pat)))
      else $error("rop code f0 did not pass the pattern");

   rop_dest_a: assert property (@(posedge clk_in) disable iff (rst_in)
      accept_s and (state_q.ctrl[7:0] == BWMD_ROP_DST) |=> (out_out.pixel == $past(pix_in.dst)))
      else $error("rop code aa did not pass the destination");

   step_left_a: assert property (@(posedge clk_in) disable iff (rst_in)
      accept_s and state_q.ctrl[BWMD_XREV_BIT] && !line_end |=> (state_q.x == $past(state_q.x) - 12'h001))
      else $error("right start did not step leftward");

   step_up_a: assert property (@(posedge clk_in) disable iff (rst_in)
      accept_s and state_q.ctrl[BWMD_YREV_BIT] && line_end && !rect_end
      |=> (state_q.y == $past(state_q.y) - 12'h001))
      else $error("bottom start did not step upward");

   next_line_a: assert property (@(posedge clk_in) disable iff (rst_in)
      accept_s and !state_q.ctrl[BWMD_XREV_BIT] && !state_q.ctrl[BWMD_YREV_BIT] && line_end && !rect_end
      |=> (state_q.x == 12'h000) && (state_q.y == $past(state_q.y) + 12'h001))
      else $error("default order did not move to the next line");

   last_count_a: assert property (@(posedge clk_in) disable iff (rst_in)
      accept_s and rect_end |=> out_out.last && !pix_ready_out
      && (state_q.pix_cnt == {12'h000, state_q.width} * {12'h000, state_q.height}))
      else $error("final pixel count differs from the rectangle size");

   right_top_a: assert property (@(posedge clk_in) disable iff (rst_in)
      start_s and state_q.ctrl[BWMD_XREV_BIT] && !state_q.ctrl[BWMD_YREV_BIT]
      |=> (state_q.x == $past(state_q.width) - 12'h001) && (state_q.y == 12'h000))
      else $error("top-right start misplaced");
endmodule
`default_nettype wire

// file: test/bwmd_sink.sv
// output-side consumer model that accepts pixels promptly or with random stalls
`default_nettype none
module bwmd_sink
(
   input  wire logic clk_in,
   input  wire logic rst_in,
   input  wire logic slow_in,
   output var  logic ready_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // ready generation
   // ----------------------------------------------------------------
   // a slow consumer stalls about half the cycles so the output slot must hold
   always @(posedge clk_in)
   begin
      if (rst_in)
         ready_out <= 1'b0;
      else
         ready_out <= slow_in ? 1'($urandom % 2) : 1'b1;
   end
endmodule
`default_nettype wire

// file: test/tb_blit_write_mask_and_direction.sv
// self-checking bench: register bus, masking and traversal order against a queue model
`default_nettype none
module tb_blit_write_mask_and_direction;
   import bwmd_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic             clk_in = 1'b0;
   logic             rst_in = 1'b1;
   logic [4:0]       addr = 5'h00;
   logic             rd = 1'b0;
   logic             wr = 1'b0;
   logic [31:0]      wdata = 32'h0;
   logic [31:0]      rdata;
   logic             wait_req;
   logic             pix_valid = 1'b0;
   bwmd_pix_in_type  pix = '0;
   logic             pix_ready;
   logic             out_valid;
   bwmd_pix_out_type out_pix;
   logic             out_ready;
   logic             busy;
   logic             slow = 1'b0;
   int               num_errors = 0;
   int               n_tests = 0;
   bwmd_pix_out_type exp_q[$];
   logic [31:0]      ctrl;
   logic [23:0]      bg;
   int               w;
   int               h;
   logic [31:0]      cfg[10];
   int               dx;
   int               dy;
   bit               seen_pos[int];

   always #4 clk_in = ~clk_in;

   bwmd_engine u_dut (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(addr), .avs_read_in(rd),
      .avs_write_in(wr), .avs_writedata_in(wdata), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_req),
      .pix_valid_in(pix_valid), .pix_in(pix), .pix_ready_out(pix_ready), .out_valid_out(out_valid),
      .out_out(out_pix), .out_ready_in(out_ready), .busy_out(busy));
   bwmd_sink u_sink (.clk_in(clk_in), .rst_in(rst_in), .slow_in(slow), .ready_out(out_ready));
   // ----------------------------------------------------------------
   // checking and closing
   // ----------------------------------------------------------------
   task automatic check(input logic [63:0] seen, input logic [63:0] expd);
      n_tests++;
      if (seen !== expd)
      begin
         num_errors++;
         $display("BAD at %0t: seen %h expected %h", $time, seen, expd);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic timed_out();
      num_errors++;
      $display("BAD at %0t: wait ran out", $time);
      end_sim();
   endtask
   // ----------------------------------------------------------------
   // avalon-mm master
   // ----------------------------------------------------------------
   task automatic bus(input logic is_wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_in);
      addr  <= a;
      wdata <= d;
      wr    <= is_wr;
      rd    <= !is_wr;
      do
      begin
         @(posedge clk_in);
         n++;
         if (n > 50)
            timed_out();
      end while (wait_req !== 1'b0);
      q  = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   // ----------------------------------------------------------------
   // reference model of one pixel
   // ----------------------------------------------------------------
   function automatic bwmd_pix_out_type model(bwmd_pix_in_type p, int k);
      bwmd_pix_out_type r;
      logic             wen;
      logic [23:0]      cv;
      for (int b = 0; b < 24; b++)
         r.pixel[b] = ctrl[{p.pat[b], p.src[b], p.dst[b]}];
      wen = 1'b1;
      if (ctrl[13] && ctrl[12] && !p.src_mono) wen = 1'b0;
      if (ctrl[17] && ctrl[18] && !p.pat_mono) wen = 1'b0;
      cv = ctrl[15] ? r.pixel : p.dst;
      if (ctrl[14] && ((cv == bg) != ctrl[16])) wen = 1'b0;
      r.byte_en = {3{wen}};
      r.x = 12'(ctrl[8] ? w - 1 - k % w : k % w);
      r.y = 12'(ctrl[9] ? h - 1 - k / w : k / w);
      r.last = (k == w * h - 1);
      return r;
   endfunction

   function automatic logic [23:0] pick();
      return ($urandom % 2) ? bg : 24'($urandom);
   endfunction

   // destination is source moved by dx,dy: a write may only land on source already read
   function automatic logic src_safe(int x, int y);
      int sx;
      int sy;
      sx = x + dx;
      sy = y + dy;
      return sx < 0 || sx >= w || sy < 0 || sy >= h || (sx == x && sy == y)
         || seen_pos.exists(sy * 4096 + sx);
   endfunction

   always @(posedge clk_in)
   begin
      if (!rst_in && out_valid === 1'b1 && out_ready === 1'b1)
      begin
         if (exp_q.size() == 0)
            check(64'(out_pix), 64'h1);
         else
            check(64'(out_pix), 64'(exp_q.pop_front()));
         check(64'(src_safe(int'(out_pix.x), int'(out_pix.y))), 64'h1);
         seen_pos[int'(out_pix.y) * 4096 + int'(out_pix.x)] = 1'b1;
      end
   end
   // ----------------------------------------------------------------
   // one transfer: program, stream pixels, wait, read status
   // ----------------------------------------------------------------
   task automatic blit();
      logic [31:0] q;
      int          n;
      seen_pos.delete();
      bus(1'b1, BWMD_ADDR_CTRL, ctrl, q);
      bus(1'b1, BWMD_ADDR_BG, {8'h00, bg}, q);
      bus(1'b1, BWMD_ADDR_SIZE, 32'(h << 16) | 32'(w), q);
      bus(1'b1, BWMD_ADDR_CMD, 32'h1, q);
      for (int k = 0; k < w * h; k++)
      begin
         pix_valid <= 1'b1;
         pix <= '{src: pick(), pat: pick(), dst: pick(), src_mono: 1'($urandom), pat_mono: 1'($urandom)};
         n = 0;
         do
         begin
            @(posedge clk_in);
            n++;
            if (n > 200)
               timed_out();
         end while (pix_ready !== 1'b1);
         exp_q.push_back(model(pix, k));
      end
      pix_valid <= 1'b0;
      n = 0;
      while (busy !== 1'b0)
      begin
         @(posedge clk_in);
         n++;
         if (n > 200)
            timed_out();
      end
      bus(1'b0, BWMD_ADDR_STATUS, 32'h0, q);
      check(64'(q[1:0]), 64'h2);
      check(64'(q[31:8]), 64'({12'(ctrl[9] ? 0 : h - 1), 12'(ctrl[8] ? 0 : w - 1)}));
      bus(1'b0, BWMD_ADDR_COUNT, 32'h0, q);
      check(64'(q[23:0]), 64'(w * h));
      check(64'(exp_q.size()), 64'h0);
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      logic [31:0] q;
      void'($urandom(32'h45df));
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      bus(1'b0, BWMD_ADDR_CTRL, 32'h0, q);
      check(64'(q), 64'(BWMD_CTRL_RESET));
      bus(1'b0, BWMD_ADDR_BG, 32'h0, q);
      check(64'(q), 64'h0);
      bus(1'b0, 5'h18, 32'h0, q);
      check(64'(q), 64'h0);
      cfg = '{32'h0000_00cc, 32'h0000_03f0, 32'h0000_01aa, 32'h0000_02cc, 32'h0000_30cc,
              32'h0000_20cc, 32'h0006_00f0, 32'h0004_00f0, 32'h0000_4000, 32'h0005_7000};
      for (int i = 0; i < 22; i++)
      begin
         dx = (i < 10) ? 0 : int'($urandom % 3) - 1;
         dy = (i < 10) ? 0 : int'($urandom % 3) - 1;
         // random cases take the corner from the overlap direction, as software must
         ctrl = (i < 10) ? cfg[i] : {13'h0, 3'(i), 2'(i >> 2), 4'h0, dy > 0, dx > 0, 8'($urandom)};
         if (i >= 18)
            ctrl = ctrl | 32'h0006_3000;
         if (i == 8 || i == 9)
            ctrl[7:0] = 8'($urandom);
         bg = 24'($urandom);
         w = 1 + $urandom % 4;
         h = 1 + $urandom % 3;
         slow = i[0];
         blit();
      end
      end_sim();
   end
endmodule
`default_nettype wire
